// [logic/lirq_routing.sv]
// legacy interrupt routing: sources, steering fields and polarity into pic requests
`timescale 1ns/10ps
module lirq_routing
  import lirq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [15:0] isa_irq_pin_in,
  input wire logic [15:0] serial_isa_slot_in,
  input wire logic pci_int_line_a_n_in,
  input wire logic pci_int_line_b_n_in,
  input wire logic pci_int_line_c_n_in,
  input wire logic pci_int_line_d_n_in,
  output logic pci_int_line_d_n_out,
  output logic pci_int_line_d_n_oe_out,
  input wire logic [3:0] serial_pci_slot_in,
  input wire logic [2:0] plugplay_int_pin_in,
  input wire logic sysint_in,
  input wire logic watchdog_style_interrupt_in,
  input wire logic kbd_request_pin_in,
  input wire logic mouse_request_pin_in,
  input wire logic usb_int_in,
  input wire logic ext_irq_en_in,
  input wire logic emul_enable_in,
  input wire logic emul_irq_en_in,
  input wire logic output_full_in,
  input wire logic aux_output_full_in,
  output logic kbd_emul_req_out,
  output logic mouse_emul_req_out,
  output logic [15:0] pic_req_n_out,
  output logic [15:0] edge_level_select_out
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic field_hit(input logic [3:0] field, input logic [3:0] req);
    field_hit = (field == req);
  endfunction : field_hit

  // ****************************************
  // configuration registers
  // ****************************************
  logic [15:0] pci_steering_word_q;
  logic [15:0] plugplay_steering_word_q;
  logic [3:0] sysint_steering_field_q;
  logic [15:0] ide_native_mode_bits_q;
  logic [3:0] pci_edge_select_bits_q;
  logic [1:0] req12_select_reg_q;
  logic [15:0] apic_control_reg_q;
  logic [15:0] edge_level_select_reg_q;
  logic [2:0] plugplay_invert_q;
  logic [31:0] rdata_q;
  logic [15:0] pic_req_n_d;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pci_steering_word_q <= LIRQ_WORD_RST;
      plugplay_steering_word_q <= LIRQ_WORD_RST;
      sysint_steering_field_q <= LIRQ_WORD_RST[3:0];
      ide_native_mode_bits_q <= LIRQ_WORD_RST;
      pci_edge_select_bits_q <= LIRQ_WORD_RST[3:0];
      req12_select_reg_q <= LIRQ_WORD_RST[1:0];
      apic_control_reg_q <= LIRQ_WORD_RST;
      edge_level_select_reg_q <= LIRQ_WORD_RST;
      plugplay_invert_q <= LIRQ_WORD_RST[2:0];
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        LIRQ_PCI_STEER_OFS: pci_steering_word_q <= reg_wdata_in[15:0];
        LIRQ_PNP_STEER_OFS: plugplay_steering_word_q <= reg_wdata_in[15:0];
        LIRQ_SYS_STEER_OFS: sysint_steering_field_q <= reg_wdata_in[3:0];
        LIRQ_IDE_NATIVE_OFS: ide_native_mode_bits_q <= reg_wdata_in[15:0];
        LIRQ_PCI_EDGE_OFS: pci_edge_select_bits_q <= reg_wdata_in[3:0];
        LIRQ_REQ12_SEL_OFS: req12_select_reg_q <= reg_wdata_in[1:0];
        LIRQ_APIC_CTRL_OFS: apic_control_reg_q <= reg_wdata_in[15:0];
        LIRQ_EDGE_LEVEL_OFS: edge_level_select_reg_q <= reg_wdata_in[15:0];
        LIRQ_PNP_INV_OFS: plugplay_invert_q <= reg_wdata_in[2:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // unmapped addresses read as zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        LIRQ_PCI_STEER_OFS: rdata_q <= {16'h0000, pci_steering_word_q};
        LIRQ_PNP_STEER_OFS: rdata_q <= {16'h0000, plugplay_steering_word_q};
        LIRQ_SYS_STEER_OFS: rdata_q <= {28'h0000000, sysint_steering_field_q};
        LIRQ_IDE_NATIVE_OFS: rdata_q <= {16'h0000, ide_native_mode_bits_q};
        LIRQ_PCI_EDGE_OFS: rdata_q <= {28'h0000000, pci_edge_select_bits_q};
        LIRQ_REQ12_SEL_OFS: rdata_q <= {30'h0, req12_select_reg_q};
        LIRQ_APIC_CTRL_OFS: rdata_q <= {16'h0000, apic_control_reg_q};
        LIRQ_EDGE_LEVEL_OFS: rdata_q <= {16'h0000, edge_level_select_reg_q};
        LIRQ_PNP_INV_OFS: rdata_q <= {29'h0, plugplay_invert_q};
        LIRQ_STATUS_OFS: rdata_q <= {16'h0000, pic_req_n_d};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_out = rdata_q;
  // sensitivity travels with the requests to the pic
  assign edge_level_select_out = edge_level_select_reg_q;

  // ****************************************
  // usb drive of pci line d
  // ****************************************
  // open drain, low only while usb interrupt active
  assign pci_int_line_d_n_out = 1'b0;
  assign pci_int_line_d_n_oe_out = usb_int_in;

  // ****************************************
  // keyboard and mouse emulation
  // ****************************************
  logic kbd_comb;
  logic mouse_comb;
  logic usb_req1;
  logic usb_req12;

  assign kbd_comb = kbd_request_pin_in & serial_isa_slot_in[1];
  assign mouse_comb = mouse_request_pin_in & serial_isa_slot_in[12];
  assign kbd_emul_req_out = kbd_comb;
  assign mouse_emul_req_out = mouse_comb;
  assign usb_req1 = ext_irq_en_in ? (emul_enable_in & emul_irq_en_in & output_full_in & ~aux_output_full_in)
                                  : kbd_comb;
  assign usb_req12 = ext_irq_en_in ? (emul_enable_in & emul_irq_en_in & output_full_in & aux_output_full_in)
                                   : mouse_comb;

  // ****************************************
  // polarized pci lines
  // ****************************************
  logic [3:0] pci_pin_n;
  logic [3:0] pci_pol;
  logic native14;
  logic native15;

  assign pci_pin_n = {pci_int_line_d_n_in, pci_int_line_c_n_in, pci_int_line_b_n_in, pci_int_line_a_n_in};
  assign native14 = ide_native_mode_bits_q[LIRQ_NATIVE_14_BIT];
  assign native15 = ide_native_mode_bits_q[LIRQ_NATIVE_15_BIT];

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      // edge follows pin, level asserts on low pin or slot
      pci_pol[l] = pci_edge_select_bits_q[l] ? pci_pin_n[l] : (~pci_pin_n[l] | serial_pci_slot_in[l]);
    end
    // native ide interrupts join line a in level mode
    if (!pci_edge_select_bits_q[0]) begin
      pci_pol[0] = pci_pol[0] | (native14 & isa_irq_pin_in[14]) | (native15 & isa_irq_pin_in[15]);
    end
  end

  // ****************************************
  // per-request routing
  // ****************************************
  logic [2:0] pnp_eff;
  logic sys_route_en;
  logic wdog_en;

  // inverter selected flips external polarity at the pic
  assign pnp_eff = plugplay_int_pin_in ^ plugplay_invert_q;
  // divert to apic blocks the legacy path
  assign sys_route_en = sysint_in & ~apic_control_reg_q[LIRQ_DIVERT_BIT];
  // enable bit gates the watchdog-style path
  assign wdog_en = watchdog_style_interrupt_in & plugplay_steering_word_q[LIRQ_WDOG_EN_BIT];

  // purely combinational from sources to requests
  always_comb begin
    logic [3:0] req;
    logic steered;
    logic pci_x;
    logic pnp_x;
    logic sys_x;
    logic wdog_x;
    logic isa_x;
    req = 4'h0;
    steered = 1'b0;
    pci_x = 1'b0;
    pnp_x = 1'b0;
    sys_x = 1'b0;
    wdog_x = 1'b0;
    isa_x = 1'b0;
    pic_req_n_d = 16'hffff;
    for (int x = 0; x < 16; x++) begin
      req = 4'(x);
      pci_x = (pci_pol[0] & field_hit(pci_steering_word_q[3:0], req))
            | (pci_pol[1] & field_hit(pci_steering_word_q[7:4], req))
            | (pci_pol[2] & field_hit(pci_steering_word_q[11:8], req))
            | (pci_pol[3] & field_hit(pci_steering_word_q[15:12], req));
      pnp_x = (pnp_eff[2] & field_hit(plugplay_steering_word_q[11:8], req))
            | (pnp_eff[1] & field_hit(plugplay_steering_word_q[7:4], req))
            | (pnp_eff[0] & field_hit(plugplay_steering_word_q[3:0], req));
      sys_x = sys_route_en & field_hit(sysint_steering_field_q, req);
      // only requests 9 to 11, matched on the low three bits
      wdog_x = wdog_en & LIRQ_WDOG_REQ_MASK[x] & (plugplay_steering_word_q[2:0] == req[2:0]);
      // any steering field on x suppresses the isa path
      steered = field_hit(pci_steering_word_q[3:0], req) | field_hit(pci_steering_word_q[7:4], req)
              | field_hit(pci_steering_word_q[11:8], req) | field_hit(pci_steering_word_q[15:12], req)
              | field_hit(plugplay_steering_word_q[11:8], req) | field_hit(plugplay_steering_word_q[7:4], req)
              | field_hit(plugplay_steering_word_q[3:0], req) | field_hit(sysint_steering_field_q, req);
      case (req)
        LIRQ_REQ1: isa_x = ~usb_req1 & ~steered;
        LIRQ_REQ12: isa_x = ~((req12_select_reg_q == LIRQ_REQ12_PIN_SEL) ? isa_irq_pin_in[12] : usb_req12)
                            & ~steered;
        // native mode removes isa paths 14 and 15
        LIRQ_REQ14: isa_x = ~(isa_irq_pin_in[14] & serial_isa_slot_in[14]) & ~steered & ~native14;
        LIRQ_REQ15: isa_x = ~(isa_irq_pin_in[15] & serial_isa_slot_in[15]) & ~steered & ~native15;
        default: isa_x = ~(isa_irq_pin_in[x] & serial_isa_slot_in[x]) & ~steered;
      endcase
      // only valid request numbers are routed
      // low while any source is asserted
      if (LIRQ_VALID_REQ_MASK[x]) begin
        pic_req_n_d[x] = ~(isa_x | pci_x | pnp_x | sys_x | wdog_x);
      end
    end
  end

  assign pic_req_n_out = pic_req_n_d;

endmodule : lirq_routing

// [logic/lirq_pkg.sv]
// constants for the legacy interrupt routing block
package lirq_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] LIRQ_PCI_STEER_OFS = 8'h00;
  localparam logic [7:0] LIRQ_PNP_STEER_OFS = 8'h04;
  localparam logic [7:0] LIRQ_SYS_STEER_OFS = 8'h08;
  localparam logic [7:0] LIRQ_IDE_NATIVE_OFS = 8'h0c;
  localparam logic [7:0] LIRQ_PCI_EDGE_OFS = 8'h10;
  localparam logic [7:0] LIRQ_REQ12_SEL_OFS = 8'h14;
  localparam logic [7:0] LIRQ_APIC_CTRL_OFS = 8'h18;
  localparam logic [7:0] LIRQ_EDGE_LEVEL_OFS = 8'h1c;
  localparam logic [7:0] LIRQ_PNP_INV_OFS = 8'h20;
  localparam logic [7:0] LIRQ_STATUS_OFS = 8'h24;
  // ****************************************
  // field positions
  // ****************************************
  localparam int LIRQ_NATIVE_14_BIT = 8;
  localparam int LIRQ_NATIVE_15_BIT = 10;
  localparam int LIRQ_WDOG_EN_BIT = 3;
  localparam int LIRQ_DIVERT_BIT = 0;
  localparam int LIRQ_FIELD_W = 4;
  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [15:0] LIRQ_WORD_RST = 16'h0000;
  localparam logic [1:0] LIRQ_REQ12_PIN_SEL = 2'b00;
  localparam logic [15:0] LIRQ_VALID_REQ_MASK = 16'hdefa;
  localparam logic [15:0] LIRQ_WDOG_REQ_MASK = 16'h0e00;
  localparam logic [3:0] LIRQ_REQ1 = 4'h1;
  localparam logic [3:0] LIRQ_REQ12 = 4'hc;
  localparam logic [3:0] LIRQ_REQ14 = 4'he;
  localparam logic [3:0] LIRQ_REQ15 = 4'hf;
endpackage : lirq_pkg

// [tb/lirq_pic_model.sv]
// behavioural model of the legacy pic request inputs
`timescale 1ns/10ps
module lirq_pic_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [15:0] req_n_in,
  input wire logic [15:0] level_sel_in,
  output logic [15:0] pending_out
);
  logic [15:0] prev_q;
  // rising edge or low level, chosen per line
  always_ff @(posedge clk_in) begin
    prev_q <= rst_in ? 16'hffff : req_n_in;
    if (rst_in) pending_out <= 16'h0000;
    else pending_out <= (level_sel_in & ~req_n_in) | (~level_sel_in & (pending_out | (req_n_in & ~prev_q)));
  end
endmodule : lirq_pic_model

// [tb/lirq_routing_chk.sv]
// port checker for the legacy interrupt routing block
`timescale 1ns/10ps
module lirq_routing_chk
  import lirq_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [15:0] serial_isa_slot_in,
  input wire logic pci_int_line_d_n_out,
  input wire logic pci_int_line_d_n_oe_out,
  input wire logic kbd_request_pin_in,
  input wire logic mouse_request_pin_in,
  input wire logic usb_int_in,
  input wire logic kbd_emul_req_out,
  input wire logic mouse_emul_req_out,
  input wire logic [15:0] pic_req_n_out,
  input wire logic [15:0] edge_level_select_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence el_wr_s;
    reg_wr_in && reg_addr_in == LIRQ_EDGE_LEVEL_OFS;
  endsequence
  sequence st_rd_s;
    reg_rd_in && reg_addr_in == LIRQ_STATUS_OFS;
  endsequence
  chk_usb_oe_follow: assert property (pci_int_line_d_n_oe_out == usb_int_in)
    else $error("line d enable wrong");
  chk_usb_pull_low: assert property (pci_int_line_d_n_oe_out |-> !pci_int_line_d_n_out)
    else $error("line d not low");
  chk_kbd_and: assert property (kbd_emul_req_out == (kbd_request_pin_in & serial_isa_slot_in[1]))
    else $error("kbd emulation input wrong");
  chk_mouse_and: assert property (mouse_emul_req_out == (mouse_request_pin_in & serial_isa_slot_in[12]))
    else $error("mouse emulation input wrong");
  chk_unused_idle: assert property (&{pic_req_n_out[0], pic_req_n_out[2], pic_req_n_out[8], pic_req_n_out[13]})
    else $error("unused request asserted");
  chk_status_read: assert property (st_rd_s |=> reg_rdata_out == {16'h0000, $past(pic_req_n_out)})
    else $error("status read wrong");
  chk_el_write: assert property (el_wr_s |=> edge_level_select_out == $past(reg_wdata_in[15:0]))
    else $error("edge level write lost");
  chk_el_hold: assert property (!reg_wr_in |=> $stable(edge_level_select_out))
    else $error("edge level changed");
endmodule : lirq_routing_chk
bind lirq_routing lirq_routing_chk chk_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .serial_isa_slot_in(serial_isa_slot_in), .pci_int_line_d_n_out(pci_int_line_d_n_out),
  .pci_int_line_d_n_oe_out(pci_int_line_d_n_oe_out), .kbd_request_pin_in(kbd_request_pin_in),
  .mouse_request_pin_in(mouse_request_pin_in), .usb_int_in(usb_int_in), .kbd_emul_req_out(kbd_emul_req_out),
  .mouse_emul_req_out(mouse_emul_req_out), .pic_req_n_out(pic_req_n_out),
  .edge_level_select_out(edge_level_select_out));

// [tb/test_lirq_routing.sv]
// self-checking bench for the legacy interrupt routing block
`timescale 1ns/10ps
module test_lirq_routing
  import lirq_pkg::*;
;
  // kind 0 request lines, 1 read data, 2 pending level lines of the pic model
  typedef struct {int due; int k; logic [31:0] v;} lirq_exp_t;
  logic clk = 0, rst = 1, wr = 0, rd = 0, d_out, d_oe, kbd_e, mouse_e;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, r, got;
  logic [15:0] isa_pin = 16'hffff, ser_isa = 16'hffff, pic_n, el_sel, pend, steer, pnpw, nat, apic, elr, ex;
  logic [3:0] pci_n = 4'hf, ser_pci = 4'h0, sysf, edg;
  logic [2:0] pnp = 3'h0, inv;
  logic [1:0] sel12;
  logic sysint = 0, wdog = 0, kbd = 1, mouse = 1, usb = 0, ext = 0, emul = 0, irqen = 0, of = 0, aof = 0;
  int errors = 0, cmp_count = 0, cyc = 0;
  lirq_exp_t q[$];
  wire pin_d = d_oe ? d_out : pci_n[3];
  always #5 clk = ~clk;
  lirq_routing dut_u (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .isa_irq_pin_in(isa_pin), .serial_isa_slot_in(ser_isa),
    .pci_int_line_a_n_in(pci_n[0]), .pci_int_line_b_n_in(pci_n[1]), .pci_int_line_c_n_in(pci_n[2]),
    .pci_int_line_d_n_in(pin_d), .pci_int_line_d_n_out(d_out), .pci_int_line_d_n_oe_out(d_oe),
    .serial_pci_slot_in(ser_pci), .plugplay_int_pin_in(pnp), .sysint_in(sysint), .watchdog_style_interrupt_in(wdog),
    .kbd_request_pin_in(kbd), .mouse_request_pin_in(mouse), .usb_int_in(usb), .ext_irq_en_in(ext),
    .emul_enable_in(emul), .emul_irq_en_in(irqen), .output_full_in(of), .aux_output_full_in(aof),
    .kbd_emul_req_out(kbd_e), .mouse_emul_req_out(mouse_e), .pic_req_n_out(pic_n), .edge_level_select_out(el_sel));
  lirq_pic_model pic_u (.clk_in(clk), .rst_in(rst), .req_n_in(pic_n), .level_sel_in(el_sel), .pending_out(pend));
  function automatic logic [15:0] exp_pic();
    logic [15:0] res;
    logic [3:0] pin, pol;
    logic u1, u12, s, st, isa;
    pin = {pci_n[3] & ~usb, pci_n[2:0]};
    res = 16'hffff;
    u1 = ext ? (emul & irqen & of & ~aof) : (kbd & ser_isa[1]);
    u12 = ext ? (emul & irqen & of & aof) : (mouse & ser_isa[12]);
    for (int i = 0; i < 4; i++) begin
      pol[i] = edg[i] ? pin[i] : ~pin[i] | ser_pci[i] | (i == 0 && (nat[8] & isa_pin[14] | nat[10] & isa_pin[15]));
    end
    for (int x = 1; x < 16; x++) begin
      s = wdog & pnpw[3] & x >= 9 & x <= 11 & pnpw[2:0] == x[2:0];
      st = sysf == x;
      s |= st & sysint & ~apic[0];
      for (int i = 0; i < 4; i++) begin
        if (steer[4*i+:4] == x) begin
          s |= pol[i];
          st = 1;
        end
        if (i < 3 && pnpw[4*i+:4] == x) begin
          s |= pnp[i] ^ inv[i];
          st = 1;
        end
      end
      isa = x == 1 ? ~u1 : x == 12 ? ~(sel12 == 2'b00 ? isa_pin[12] : u12) : ~(isa_pin[x] & ser_isa[x]);
      if (x == 14 && nat[8] || x == 15 && nat[10]) isa = 0;
      if (LIRQ_VALID_REQ_MASK[x]) res[x] = ~(s | isa & ~st);
    end
    return res;
  endfunction : exp_pic
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(negedge clk);
    q.push_back('{cyc + 1, 1, e});
    @(posedge clk);
    rd <= 0;
  endtask : rd_reg
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) cyc++;
  // compare at the falling edge, away from the edge that launches the outputs
  always @(negedge clk) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      cmp_count++;
      got = q[0].k == 1 ? rdata : q[0].k == 2 ? {16'h0000, pend & el_sel} : {16'h0000, pic_n};
      if (got !== q[0].v) begin
        errors++;
        $display("mismatch %0t kind %0d got %h expected %h", $time, q[0].k, got, q[0].v);
      end
      void'(q.pop_front());
    end
  end
  initial begin
    #100us;
    errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(72));
    repeat (10) @(posedge clk);
    rst <= 0;
    {steer, pnpw, nat, apic, elr, sysf, edg, inv, sel12} = '0;
    for (int a = 0; a < 'h24; a += 4) rd_reg(a[7:0], 32'h0);
    rd_reg(8'h28, 32'h0);
    wr_reg(LIRQ_STATUS_OFS, 32'h0);
    rd_reg(LIRQ_STATUS_OFS, {16'h0000, exp_pic()});
    for (int n = 0; n < 200; n++) begin
      if (n % 4 == 0) begin
        {steer, pnpw} = $urandom;
        {nat, apic} = $urandom;
        r = $urandom;
        {elr, sysf, edg, inv, sel12} = r[28:0];
        wr_reg(LIRQ_PCI_STEER_OFS, {16'hffff, steer});
        wr_reg(LIRQ_PNP_STEER_OFS, {16'h0000, pnpw});
        wr_reg(LIRQ_SYS_STEER_OFS, {28'h0, sysf});
        wr_reg(LIRQ_IDE_NATIVE_OFS, {16'h0000, nat});
        wr_reg(LIRQ_PCI_EDGE_OFS, {28'h0, edg});
        wr_reg(LIRQ_REQ12_SEL_OFS, {30'h0, sel12});
        wr_reg(LIRQ_APIC_CTRL_OFS, {16'h0000, apic});
        wr_reg(LIRQ_PNP_INV_OFS, {29'h0, inv});
        wr_reg(LIRQ_EDGE_LEVEL_OFS, {16'h0000, elr});
        rd_reg(LIRQ_PCI_STEER_OFS, {16'h0000, steer});
      end
      @(posedge clk);
      r = $urandom;
      isa_pin <= 16'($urandom);
      // keyboard controller keeps slots 1 and 12 low while emulation owns requests 1 and 12
      ser_isa <= 16'($urandom) & (r[8] ? 16'heffd : 16'hffff);
      {ext, irqen, of, aof, kbd, mouse, usb, sysint, wdog} <= r[8:0];
      emul <= r[9];
      {pci_n, ser_pci, pnp} <= r[20:10];
      @(negedge clk);
      ex = exp_pic();
      q.push_back('{cyc + 1, 0, {16'h0000, ex}});
      q.push_back('{cyc + 1, 2, {16'h0000, ~ex & elr}});
      rd_reg(LIRQ_STATUS_OFS, {16'h0000, ex});
    end
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    rd_reg(LIRQ_EDGE_LEVEL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    give_verdict();
  end
endmodule : test_lirq_routing
